// >>> verilog/tcsc_params.svh
// Constants of the timer compare status control block: offsets, field
// positions, reset values and widths.
// Assumes inclusion by bare name from the package, the top module and the bench.
`ifndef TCSC_PARAMS_SVH
`define TCSC_PARAMS_SVH

// ==========================================================================
// Widths
`define TCSC_AW 8
`define TCSC_DW 8
`define TCSC_NCH 2
`define TCSC_NIRQ 6

// ==========================================================================
// Register offsets: channel blocks at 8'h00 and 8'h08, word index in [2:0]
`define TCSC_CH_SEL_BIT 3
`define TCSC_OFS_STATUS 3'h0
`define TCSC_OFS_CTRL 3'h1
`define TCSC_OFS_COUNT 3'h2
`define TCSC_OFS_CMPA 3'h3
`define TCSC_OFS_CMPB 3'h4
`define TCSC_OFS_IRQ_STAT 8'h10
`define TCSC_OFS_IRQ_MASK 8'h11

// ==========================================================================
// Status/control register fields
`define TCSC_BIT_FLAG_B 7
`define TCSC_BIT_FLAG_A 6
`define TCSC_BIT_FLAG_OV 5
`define TCSC_BIT_TRIG 4
`define TCSC_ACT_B_MSB 3
`define TCSC_ACT_B_LSB 2
`define TCSC_ACT_A_MSB 1
`define TCSC_ACT_A_LSB 0

// Control register fields
`define TCSC_BIT_OVERFLOW_IRQ_ENABLE 5
`define TCSC_CLR_MSB 4
`define TCSC_CLR_LSB 3

// ==========================================================================
// Reset values
`define TCSC_RST_RSV_B4 1'b1
`define TCSC_RST_CMP 8'hff
`define TCSC_RST_CNT 8'h00
`define TCSC_CNT_MAX 8'hff

`endif

// >>> verilog/tcsc_pkg.sv
// Types shared by the timer compare status control block.
// Assumes tcsc_params.svh is on the include path.
`include "tcsc_params.svh"

package tcsc_pkg;

    // ======================================================================
    // Pin action on a compare match
    typedef enum logic [1:0] {
        TCSC_ACT_KEEP = 2'h0,
        TCSC_ACT_LOW = 2'h1,
        TCSC_ACT_HIGH = 2'h2,
        TCSC_ACT_TOGGLE = 2'h3
    } tcsc_act_e;

    // Counter clear source
    typedef enum logic [1:0] {
        TCSC_CLR_NONE = 2'h0,
        TCSC_CLR_MATCH_A = 2'h1,
        TCSC_CLR_MATCH_B = 2'h2,
        TCSC_CLR_EXT = 2'h3
    } tcsc_clr_e;

    // ======================================================================
    // One channel's software-visible state; flags and armed are {b, a, ov}
    typedef struct packed {
        logic [`TCSC_DW-1:0] cmp_a;
        logic [`TCSC_DW-1:0] cmp_b;
        logic [2:0] flags;
        logic [2:0] armed;
        tcsc_act_e act_b;
        tcsc_act_e act_a;
        logic trig_en;
        logic overflow_irq_enable;
        tcsc_clr_e clr_sel;
        logic pin;
    } tcsc_chan_s;

    // Whole state of the top module
    typedef struct packed {
        tcsc_chan_s [`TCSC_NCH-1:0] ch;
        logic [`TCSC_NIRQ-1:0] irq_stat;
        logic [`TCSC_NIRQ-1:0] irq_mask;
        logic adc_req;
        logic [`TCSC_DW-1:0] rdata;
    } tcsc_state_s;

endpackage

// >>> verilog/tcsc_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs are levels that stay put for at least two clocks.
`timescale 1ns/1ps

module tcsc_sync #(
    parameter int W = 1
) (
    // System
    input wire logic clk,
    input wire logic reset,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } tcsc_sync_s;

    tcsc_sync_s s_q;
    tcsc_sync_s s_d;

    // ======================================================================
    // Elaboration check
    if (W < 1) begin : g_bad_w
        $error("tcsc_sync: W must be at least 1");
    end

    // Next state: first flop is read only by the second
    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// >>> verilog/tcsc_counter.sv
// Up counter of one timer channel with clear select and match detection.
// Assumes count_tick and load come from logic on clk; ext_rst is synchronised.
`timescale 1ns/1ps

module tcsc_counter import tcsc_pkg::*; #(
    parameter int CNT_W = 8
) (
    // System
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic count_tick,
    input wire logic ext_rst,
    input tcsc_clr_e clr_sel,
    input wire logic [CNT_W-1:0] cmp_a,
    input wire logic [CNT_W-1:0] cmp_b,
    // Software load
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // Results
    output logic [CNT_W-1:0] count,
    output logic [2:0] events
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [2:0] ev;
        logic ext_prev;
    } tcsc_cnt_s;

    tcsc_cnt_s s_q;
    tcsc_cnt_s s_d;

    // ======================================================================
    // Elaboration check
    if (CNT_W < 2) begin : g_bad_w
        $error("tcsc_counter: CNT_W must be at least 2");
    end

    // Next state: load, external clear, then counting
    always_comb begin
        s_d = s_q;
        s_d.ev = 3'h0;
        s_d.ext_prev = ext_rst;
        if (load) begin
            s_d.cnt = load_val;
        end else if (clr_sel == TCSC_CLR_EXT && ext_rst && !s_q.ext_prev) begin
            s_d.cnt = '0;
        end else if (count_tick) begin
            if ((clr_sel == TCSC_CLR_MATCH_A && s_q.cnt == cmp_a) ||
                (clr_sel == TCSC_CLR_MATCH_B && s_q.cnt == cmp_b)) begin
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
                s_d.ev[0] = &s_q.cnt;
            end
            s_d.ev[1] = (s_d.cnt == cmp_a);
            s_d.ev[2] = (s_d.cnt == cmp_b);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
    assign events = s_q.ev;

    // ======================================================================
    // Checks
    property p_clear_on_a;
        @(posedge clk) disable iff (reset)
        (!load && count_tick && clr_sel == TCSC_CLR_MATCH_A && s_q.cnt == cmp_a &&
         !(ext_rst && !s_q.ext_prev && clr_sel == TCSC_CLR_EXT)) |=> (s_q.cnt == '0);
    endproperty
    a_clear_on_a: assert property (p_clear_on_a)
        else $error("counter not cleared on match A");

endmodule

// >>> verilog/tcsc_top.sv
// Timer compare status control: flags, pin actions, conversion trigger,
// counters and interrupts of two 8-bit timer channels.
// Assumes count ticks come from a prescaler on clk and the external counter
// reset pins are asynchronous.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tcsc_params.svh"

module tcsc_top import tcsc_pkg::*; (
    // System
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [`TCSC_AW-1:0] reg_addr,
    input wire logic [`TCSC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`TCSC_DW-1:0] reg_rdata,
    // Counter time base, one-cycle ticks on clk
    input wire logic [`TCSC_NCH-1:0] count_tick,
    // External counter reset pins
    input wire logic [`TCSC_NCH-1:0] ext_counter_reset,
    // Timer output pins
    output logic timer0_output_pin,
    output logic timer1_output_pin,
    // Requests
    output logic adc_start_req,
    output logic [`TCSC_NCH-1:0] overflow_irq_request,
    output logic irq
);

    tcsc_state_s s_q;
    tcsc_state_s s_d;

    logic [`TCSC_NCH-1:0] ext_rst_sync;
    logic [`TCSC_NCH-1:0] hit_ch;
    logic [`TCSC_NCH-1:0] wr_status;
    logic [`TCSC_NCH-1:0] rd_status;
    logic [`TCSC_NCH-1:0][`TCSC_DW-1:0] count;
    logic [`TCSC_NCH-1:0][2:0] events;

    // ======================================================================
    // Pin action on a match
    function automatic logic pin_next(input tcsc_act_e act, input logic cur);
        logic nxt;
        nxt = cur;
        case (act)
            TCSC_ACT_KEEP: nxt = cur;
            TCSC_ACT_LOW: nxt = 1'b0;
            TCSC_ACT_HIGH: nxt = 1'b1;
            TCSC_ACT_TOGGLE: nxt = ~cur;
            default: nxt = cur;
        endcase
        return nxt;
    endfunction

    // ======================================================================
    // Synchronise the external counter reset pins
    tcsc_sync #(
        .W(`TCSC_NCH)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(ext_counter_reset),
        .sync_out(ext_rst_sync)
    );

    // ======================================================================
    // Per-channel decode and counter
    for (genvar g = 0; g < `TCSC_NCH; g++) begin : g_ch
        // Channel block select and status access strobes
        assign hit_ch[g] = (reg_addr[`TCSC_AW-1:`TCSC_CH_SEL_BIT+1] == '0) &&
                           (reg_addr[`TCSC_CH_SEL_BIT] == 1'(g));
        assign wr_status[g] = reg_wr && hit_ch[g] &&
                              reg_addr[`TCSC_CH_SEL_BIT-1:0] == `TCSC_OFS_STATUS;
        assign rd_status[g] = reg_rd && hit_ch[g] &&
                              reg_addr[`TCSC_CH_SEL_BIT-1:0] == `TCSC_OFS_STATUS;

        tcsc_counter #(
            .CNT_W(`TCSC_DW)
        ) u_cnt (
            .clk(clk),
            .reset(reset),
            .count_tick(count_tick[g]),
            .ext_rst(ext_rst_sync[g]),
            .clr_sel(s_q.ch[g].clr_sel),
            .cmp_a(s_q.ch[g].cmp_a),
            .cmp_b(s_q.ch[g].cmp_b),
            .load(reg_wr && hit_ch[g] &&
                  reg_addr[`TCSC_CH_SEL_BIT-1:0] == `TCSC_OFS_COUNT),
            .load_val(reg_wdata),
            .count(count[g]),
            .events(events[g])
        );
    end

    // ======================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;
        s_d.adc_req = 1'b0;

        for (int c = 0; c < `TCSC_NCH; c++) begin
            // Read of status arms every flag seen as one
            if (rd_status[c]) begin
                s_d.ch[c].armed = s_q.ch[c].armed | s_q.ch[c].flags;
            end

            // Status write: clear armed flags written zero, ones ignored
            if (wr_status[c]) begin
                for (int k = 0; k < 3; k++) begin
                    if (!reg_wdata[`TCSC_BIT_FLAG_OV + k] && s_q.ch[c].armed[k]) begin
                        s_d.ch[c].flags[k] = 1'b0;
                    end
                end
                s_d.ch[c].armed = 3'h0;
                s_d.ch[c].act_b = tcsc_act_e'(reg_wdata[`TCSC_ACT_B_MSB:`TCSC_ACT_B_LSB]);
                s_d.ch[c].act_a = tcsc_act_e'(reg_wdata[`TCSC_ACT_A_MSB:`TCSC_ACT_A_LSB]);
                if (c == 0) begin
                    s_d.ch[c].trig_en = reg_wdata[`TCSC_BIT_TRIG];
                end
            end

            // Events set flags after any clear, so the set wins
            s_d.ch[c].flags = s_d.ch[c].flags | events[c];

            // Other channel registers
            if (reg_wr && hit_ch[c]) begin
                case (reg_addr[`TCSC_CH_SEL_BIT-1:0])
                    `TCSC_OFS_CTRL: begin
                        s_d.ch[c].overflow_irq_enable = reg_wdata[`TCSC_BIT_OVERFLOW_IRQ_ENABLE];
                        s_d.ch[c].clr_sel =
                            tcsc_clr_e'(reg_wdata[`TCSC_CLR_MSB:`TCSC_CLR_LSB]);
                    end
                    `TCSC_OFS_CMPA: s_d.ch[c].cmp_a = reg_wdata;
                    `TCSC_OFS_CMPB: s_d.ch[c].cmp_b = reg_wdata;
                    default: ;
                endcase
            end

            // Pin action: match A first, match B applied last to the result of A
            if (events[c][1]) begin
                s_d.ch[c].pin = pin_next(s_q.ch[c].act_a, s_q.ch[c].pin);
            end
            if (events[c][2]) begin
                s_d.ch[c].pin = pin_next(s_q.ch[c].act_b, s_d.ch[c].pin);
            end

            // Read data for this channel
            if (reg_rd && hit_ch[c]) begin
                case (reg_addr[`TCSC_CH_SEL_BIT-1:0])
                    `TCSC_OFS_STATUS: begin
                        s_d.rdata[`TCSC_BIT_FLAG_B:`TCSC_BIT_FLAG_OV] = s_q.ch[c].flags;
                        s_d.rdata[`TCSC_BIT_TRIG] =
                            (c == 0) ? s_q.ch[c].trig_en : `TCSC_RST_RSV_B4;
                        s_d.rdata[`TCSC_ACT_B_MSB:`TCSC_ACT_B_LSB] = s_q.ch[c].act_b;
                        s_d.rdata[`TCSC_ACT_A_MSB:`TCSC_ACT_A_LSB] = s_q.ch[c].act_a;
                    end
                    `TCSC_OFS_CTRL: begin
                        s_d.rdata[`TCSC_BIT_OVERFLOW_IRQ_ENABLE] = s_q.ch[c].overflow_irq_enable;
                        s_d.rdata[`TCSC_CLR_MSB:`TCSC_CLR_LSB] = s_q.ch[c].clr_sel;
                    end
                    `TCSC_OFS_COUNT: s_d.rdata = count[c];
                    `TCSC_OFS_CMPA: s_d.rdata = s_q.ch[c].cmp_a;
                    `TCSC_OFS_CMPB: s_d.rdata = s_q.ch[c].cmp_b;
                    default: s_d.rdata = '0;
                endcase
            end
        end

        // Conversion start pulse from channel 0 match A
        s_d.adc_req = events[0][1] && s_q.ch[0].trig_en;

        // Interrupt status: write one clears, new events win
        if (reg_wr && reg_addr == `TCSC_OFS_IRQ_STAT) begin
            s_d.irq_stat = s_q.irq_stat & ~reg_wdata[`TCSC_NIRQ-1:0];
        end
        s_d.irq_stat = s_d.irq_stat | {events[1], events[0]};
        if (reg_wr && reg_addr == `TCSC_OFS_IRQ_MASK) begin
            s_d.irq_mask = reg_wdata[`TCSC_NIRQ-1:0];
        end
        if (reg_rd && reg_addr == `TCSC_OFS_IRQ_STAT) begin
            s_d.rdata = {2'h0, s_q.irq_stat};
        end
        if (reg_rd && reg_addr == `TCSC_OFS_IRQ_MASK) begin
            s_d.rdata = {2'h0, s_q.irq_mask};
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            for (int c = 0; c < `TCSC_NCH; c++) begin
                s_q.ch[c].cmp_a <= `TCSC_RST_CMP;
                s_q.ch[c].cmp_b <= `TCSC_RST_CMP;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    assign reg_rdata = s_q.rdata;
    assign timer0_output_pin = s_q.ch[0].pin;
    assign timer1_output_pin = s_q.ch[1].pin;
    assign adc_start_req = s_q.adc_req;
    assign irq = |(s_q.irq_stat & s_q.irq_mask);
    // Overflow request levels
    assign overflow_irq_request[0] = s_q.ch[0].flags[0] && s_q.ch[0].overflow_irq_enable;
    assign overflow_irq_request[1] = s_q.ch[1].flags[0] && s_q.ch[1].overflow_irq_enable;

    // ======================================================================
    // Checks
    property p_flag_b_set;
        @(posedge clk) disable iff (reset)
        events[0][2] && count[0] == s_q.ch[0].cmp_b |=> s_q.ch[0].flags[2];
    endproperty
    a_flag_b_set: assert property (p_flag_b_set)
        else $error("match B flag not set");

    property p_flag_a_set;
        @(posedge clk) disable iff (reset)
        events[0][1] |-> count[0] == s_q.ch[0].cmp_a ##1 s_q.ch[0].flags[1];
    endproperty
    a_flag_a_set: assert property (p_flag_a_set)
        else $error("match A flag not set");

    property p_ov_set;
        @(posedge clk) disable iff (reset)
        events[0][0] |-> count[0] == `TCSC_RST_CNT ##1 s_q.ch[0].flags[0];
    endproperty
    a_ov_set: assert property (p_ov_set)
        else $error("overflow flag not set after wrap");

    property p_clear_needs_read;
        @(posedge clk) disable iff (reset)
        $fell(s_q.ch[0].flags[1]) |->
            $past(wr_status[0] && !reg_wdata[`TCSC_BIT_FLAG_A] && s_q.ch[0].armed[1]);
    endproperty
    a_clear_needs_read: assert property (p_clear_needs_read)
        else $error("flag cleared without read-then-zero-write");

    property p_write_one_ignored;
        @(posedge clk) disable iff (reset)
        wr_status[0] && reg_wdata[`TCSC_BIT_FLAG_B] && !s_q.ch[0].flags[2] &&
            !events[0][2] |=> !s_q.ch[0].flags[2];
    endproperty
    a_write_one_ignored: assert property (p_write_one_ignored)
        else $error("writing one set a flag");

    property p_adc_req;
        @(posedge clk) disable iff (reset)
        adc_start_req |-> $past(events[0][1] && s_q.ch[0].trig_en);
    endproperty
    a_adc_req: assert property (p_adc_req)
        else $error("conversion start without enabled match A");

    property p_rsv_reads_one;
        @(posedge clk) disable iff (reset)
        rd_status[1] |=> reg_rdata[`TCSC_BIT_TRIG];
    endproperty
    a_rsv_reads_one: assert property (p_rsv_reads_one)
        else $error("reserved bit read as zero");

    property p_pin_low_on_b;
        @(posedge clk) disable iff (reset)
        events[0][2] && s_q.ch[0].act_b == TCSC_ACT_LOW |=> !timer0_output_pin;
    endproperty
    a_pin_low_on_b: assert property (p_pin_low_on_b)
        else $error("pin not driven low on match B");

    property p_pin_toggle_on_a;
        @(posedge clk) disable iff (reset)
        events[1][1] && !events[1][2] && s_q.ch[1].act_a == TCSC_ACT_TOGGLE |=>
            timer1_output_pin != $past(timer1_output_pin);
    endproperty
    a_pin_toggle_on_a: assert property (p_pin_toggle_on_a)
        else $error("pin not toggled on match A");

    property p_ch1_flag_b;
        @(posedge clk) disable iff (reset)
        events[1][2] |=> s_q.ch[1].flags[2] ##1 s_q.ch[0].flags[2] == $past(s_q.ch[0].flags[2])
            || $past(events[0][2]) || $past(wr_status[0]);
    endproperty
    a_ch1_flag_b: assert property (p_ch1_flag_b)
        else $error("channel 1 match B flag not independent");

    property p_ovf_request;
        @(posedge clk) disable iff (reset)
        events[0][0] && s_q.ch[0].overflow_irq_enable && !(reg_wr && hit_ch[0]) |=>
            overflow_irq_request[0];
    endproperty
    a_ovf_request: assert property (p_ovf_request)
        else $error("overflow request missing");

    property p_set_wins;
        @(posedge clk) disable iff (reset)
        wr_status[0] && !reg_wdata[`TCSC_BIT_FLAG_OV] && events[0][0] |=>
            s_q.ch[0].flags[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag event lost to clearing write");

    property p_clear_armed;
        @(posedge clk) disable iff (reset)
        wr_status[1] && !reg_wdata[`TCSC_BIT_FLAG_B] && s_q.ch[1].armed[2] &&
            !events[1][2] |=> !s_q.ch[1].flags[2];
    endproperty
    a_clear_armed: assert property (p_clear_armed)
        else $error("armed flag not cleared by zero write");

    property p_pin_high_on_a;
        @(posedge clk) disable iff (reset)
        events[0][1] && !events[0][2] && s_q.ch[0].act_a == TCSC_ACT_HIGH |=>
            timer0_output_pin;
    endproperty
    a_pin_high_on_a: assert property (p_pin_high_on_a)
        else $error("pin not driven high on match A");

    property p_irq_stat_set;
        @(posedge clk) disable iff (reset)
        events[0][0] |=> s_q.irq_stat[0];
    endproperty
    a_irq_stat_set: assert property (p_irq_stat_set)
        else $error("overflow event missing from interrupt status");

    property p_rdata_idle;
        @(posedge clk) disable iff (reset)
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle after a cycle without read");

endmodule

// >>> tb/tcsc_top_tb.sv
// Self-checking bench of the timer compare status control block.
// Assumes tcsc_pkg and tcsc_top are compiled first; the bench drives every port.
`timescale 1ns/1ps
`include "tcsc_params.svh"

module tcsc_top_tb import tcsc_pkg::*;;

    // ======================================================================
    // Signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] count_tick = 2'h0;
    logic [1:0] ext_counter_reset = 2'h0;
    logic [1:0] pins;
    logic adc_start_req;
    logic [1:0] overflow_irq_request;
    logic irq;
    logic [7:0] rd_v;
    logic [1:0] pin_m = 2'h0;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    tcsc_top tcsc_top_inst (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .count_tick(count_tick), .ext_counter_reset(ext_counter_reset),
        .timer0_output_pin(pins[0]), .timer1_output_pin(pins[1]),
        .adc_start_req(adc_start_req), .overflow_irq_request(overflow_irq_request),
        .irq(irq)
    );

    // Clock at 25 MHz
    always #20 clk = ~clk;

    // Hang guard: counts as a mismatch and closes the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ======================================================================
    // Tasks and expectation functions
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask

    // One tick, then wait until its flag and pin action show
    task automatic tick_settle(input int c);
        @(posedge clk);
        count_tick[c] <= 1'b1;
        @(posedge clk);
        count_tick[c] <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    function automatic logic exp_pin(input logic [1:0] act, input logic old);
        case (act)
            2'h0: return old;
            2'h1: return 1'b0;
            2'h2: return 1'b1;
            default: return ~old;
        endcase
    endfunction

    // ======================================================================
    // Main sequence
    initial begin
        logic [7:0] b;
        logic [7:0] r;
        logic [7:0] cfg;
        logic [1:0] code;
        logic sb;
        int c;
        void'($urandom(54));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(8'h00);
        check("status0 reset", rd_v, 8'h00);
        rd(8'h08);
        check("status1 reset", rd_v, 8'h10);
        wr(8'h00, 8'he0);
        wr(8'h08, 8'h00);
        rd(8'h00);
        check("status0 ones", rd_v, 8'h00);
        rd(8'h08);
        check("status1 rsv", rd_v, 8'h10);
        rd(8'h20);
        check("unmapped", rd_v, 8'h00);
        $display("test reset and access done");
        // Every action code, both matches, both channels, random compare values
        for (int i = 0; i < 16; i++) begin
            c = (i / 4) % 2;
            sb = (i >= 8);
            code = 2'(i % 4);
            b = (c == 1) ? 8'h08 : 8'h00;
            r = 8'($urandom_range(255, 1));
            cfg = sb ? {4'h0, code, 2'h0} : {6'h0, code};
            cfg[4] = (c == 0 && !sb) ? code[0] : 1'b0;
            wr(b, cfg);
            wr(b + 8'h03, sb ? (r ^ 8'h80) : r);
            wr(b + 8'h04, sb ? r : (r ^ 8'h80));
            wr(b + 8'h02, r - 8'h01);
            tick_settle(c);
            check("pin", 8'(pins[c]), 8'(exp_pin(code, pin_m[c])));
            pin_m[c] = exp_pin(code, pin_m[c]);
            check("adc req", 8'(adc_start_req), 8'(cfg[4]));
            wr(b, cfg);
            rd(b);
            check("flag set", rd_v, cfg | (sb ? 8'h80 : 8'h40) | (c ? 8'h10 : 8'h00));
            wr(b, cfg);
            rd(b);
            check("flag cleared", rd_v, cfg | (c ? 8'h10 : 8'h00));
        end
        $display("test match actions done");
        // Overflow flag, its request and the masked interrupt line
        wr(`TCSC_OFS_IRQ_STAT, 8'h3f);
        wr(`TCSC_OFS_IRQ_MASK, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h20);
        wr(8'h02, 8'hff);
        tick_settle(0);
        check("ovf request", 8'(overflow_irq_request), 8'h01);
        check("irq masked", 8'(irq), 8'h00);
        rd(8'h00);
        check("ovf flag", rd_v & 8'h20, 8'h20);
        wr(`TCSC_OFS_IRQ_MASK, 8'h01);
        #1 check("irq on", 8'(irq), 8'h01);
        wr(8'h01, 8'h00);
        #1 check("ovf request off", 8'(overflow_irq_request), 8'h00);
        wr(`TCSC_OFS_IRQ_STAT, 8'h01);
        #1 check("irq cleared", 8'(irq), 8'h00);
        $display("test overflow done");
        // Flag event in the same cycle as its clearing write
        wr(8'h03, 8'h20);
        wr(8'h04, 8'h90);
        wr(8'h02, 8'h1f);
        tick_settle(0);
        rd(8'h00);
        check("armed flag", rd_v & 8'h40, 8'h40);
        wr(8'h02, 8'h1f);
        @(posedge clk);
        count_tick[0] <= 1'b1;
        @(posedge clk);
        count_tick[0] <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 8'h00;
        @(posedge clk);
        reg_wr <= 1'b0;
        rd(8'h00);
        check("set beats clear", rd_v & 8'h40, 8'h40);
        $display("test set over clear done");
        // Counter clear sources on channel 1
        wr(8'h0b, 8'h05);
        wr(8'h0c, 8'h07);
        for (int s = 0; s < 3; s++) begin
            wr(8'h09, 8'(s << 3));
            wr(8'h0a, (s == 2) ? 8'h06 : 8'h04);
            tick_settle(1);
            tick_settle(1);
            rd(8'h0a);
            check("clear sel", rd_v, (s == 0) ? 8'h06 : 8'h00);
        end
        wr(8'h09, 8'h18);
        wr(8'h0a, 8'h33);
        @(posedge clk);
        ext_counter_reset[1] <= 1'b1;
        repeat (6) @(posedge clk);
        rd(8'h0a);
        check("ext clear", rd_v, 8'h00);
        ext_counter_reset[1] <= 1'b0;
        $display("test clear select done");
        wrap_up();
    end

endmodule
